// ### design/sfpd_top.sv
`timescale 1ns/10ps
`default_nettype none
module sfpd_top
   import sfpd_pkg::*;
#(
   parameter int MEM_ADDR_W = 19,
   parameter int PAGE_WRITE_TIME_US = 1000,
   parameter int SECTOR_CLEAR_TIME_US = 10000,
   parameter int ARRAY_CLEAR_TIME_US = 20000,
   parameter logic [7:0] WRITE_UNLOCK_CMD = 8'h31,
   parameter logic [7:0] PAGE_WRITE_CMD = 8'h32,
   parameter logic [7:0] SECTOR_CLEAR_CMD = 8'h33,
   parameter logic [7:0] ARRAY_CLEAR_CMD = 8'h34,
   parameter logic [7:0] SLEEP_ENTRY_CMD = 8'h35,
   parameter logic [7:0] WAKE_AND_ID_CMD = 8'h36,
   parameter logic [7:0] SIGNATURE = 8'h5a // Arbitrary value
)(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic spi_cs_n,
   input wire logic spi_sclk,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   input wire logic protect_size_bit2,
   input wire logic protect_size_bit1,
   input wire logic protect_size_bit0,
   input wire logic [MEM_ADDR_W-1:0] peek_addr,
   output logic [7:0] peek_data,
   output logic write_unlock_latch,
   output logic cycle_in_progress_flag,
   output logic deep_sleep
);
   localparam int SECT_W = MEM_ADDR_W - SECT_IDX_W;
   localparam int PAGE_WRITE_CYC = sfpd_cyc(PAGE_WRITE_TIME_US);
   localparam int SECTOR_CLEAR_CYC = sfpd_cyc(SECTOR_CLEAR_TIME_US);
   localparam int ARRAY_CLEAR_CYC = sfpd_cyc(ARRAY_CLEAR_TIME_US);
   localparam logic [MEM_ADDR_W-1:0] PAGE_END = {{(MEM_ADDR_W-PAGE_W){1'b0}}, {PAGE_W{1'b1}}};
   localparam logic [MEM_ADDR_W-1:0] SECT_END = {{SECT_IDX_W{1'b0}}, {SECT_W{1'b1}}};

   logic [1:0] rst_sync_r;
   logic rst_n;
   sfpd_spi_t pin_s, prev_r;
   logic cs_rise, sclk_rise, sclk_fall, byte_done, unlock_dec;
   sfpd_frame_t frame_r, frame_nxt;
   sfpd_op_t op_r;
   sfpd_kind_t kind_r;
   logic [7:0] shift_r, rx_byte, opc_r, data_idx_r;
   logic [2:0] bit_cnt_r, byte_cnt_r, sig_idx_r, bp;
   logic [23:0] addr_r;
   logic [7:0] buf_r [0:(1<<PAGE_W)-1];
   logic [(1<<PAGE_W)-1:0] buf_vld_r;
   logic sig_done_r, miso_r, wel_r;
   logic [31:0] tmr_r;
   logic [MEM_ADDR_W-1:0] walk_base_r, walk_cnt_r, walk_end_r;
   logic walk_done_r;
   logic asleep, aligned, hit;
   logic [SECT_IDX_W-1:0] sec_idx;
   logic go_prog, go_sect, go_array, go_busy, go_sleep, go_wake;
   logic mem_we, mem_and_en;
   logic [7:0] mem_wdata;

   function automatic logic prot_hit(input logic [2:0] b, input logic [SECT_IDX_W-1:0] s);
      logic [3:0] first;
      first = SECTORS;
      if (b >= BP_ALL)
         first = 4'h0;
      else if (b != 3'h0)
         first = SECTORS - (4'h1 << (b - 3'h1));
      return {1'b0, s} >= first;
   endfunction

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         rst_sync_r <= 2'b00;
      else
         rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_n = rst_sync_r[1];

   sfpd_sync #(.W(3), .RST_VAL(3'b100)) u_pin_sync (
      .clk(clk_sys),
      .rst_n(rst_n),
      .d({spi_cs_n, spi_sclk, spi_mosi}),
      .q(pin_s)
   );

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         prev_r <= 3'b100;
      else
         prev_r <= pin_s;
   end

   assign cs_rise = pin_s.cs_n && !prev_r.cs_n;
   assign sclk_rise = !pin_s.cs_n && pin_s.sclk && !prev_r.sclk;
   assign sclk_fall = !pin_s.cs_n && !pin_s.sclk && prev_r.sclk;
   assign rx_byte = {shift_r[6:0], pin_s.mosi};
   assign byte_done = sclk_rise && bit_cnt_r == 3'h7;
   assign asleep = op_r == O_SLEEP || op_r == O_SLEEP_WAIT;
   assign bp = {protect_size_bit2, protect_size_bit1, protect_size_bit0};

   // Frame decoder: decides at each opcode byte whether the frame is heard
   always_comb
   begin
      frame_nxt = frame_r;
      unique case (frame_r)
         F_OPC:
         begin
            if (op_r == O_BUSY || op_r == O_WAKE_WAIT)
               frame_nxt = F_IGN;
            else if (asleep && rx_byte != WAKE_AND_ID_CMD)
               frame_nxt = F_IGN;
            else if (rx_byte == WRITE_UNLOCK_CMD || rx_byte == PAGE_WRITE_CMD ||
                     rx_byte == SECTOR_CLEAR_CMD || rx_byte == ARRAY_CLEAR_CMD ||
                     rx_byte == SLEEP_ENTRY_CMD || rx_byte == WAKE_AND_ID_CMD)
               frame_nxt = F_ARG;
            else
               frame_nxt = F_IGN;
         end
         F_ARG:
         begin
            if (byte_cnt_r == CNT_ADDR_LAST && opc_r == PAGE_WRITE_CMD)
               frame_nxt = F_DATA;
            else if (byte_cnt_r == CNT_ADDR_LAST && opc_r == WAKE_AND_ID_CMD)
               frame_nxt = F_SIG;
         end
         F_DATA, F_SIG, F_IGN:
            frame_nxt = frame_r;
      endcase
   end

   assign unlock_dec = byte_done && frame_r == F_OPC && frame_nxt == F_ARG && rx_byte == WRITE_UNLOCK_CMD;

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         frame_r <= F_OPC;
         shift_r <= 8'h00;
         bit_cnt_r <= 3'h0;
         byte_cnt_r <= 3'h0;
         opc_r <= 8'h00;
         addr_r <= 24'h000000;
      end
      else if (pin_s.cs_n)
      begin
         frame_r <= F_OPC;
         bit_cnt_r <= 3'h0;
         byte_cnt_r <= 3'h0;
      end
      else if (sclk_rise)
      begin
         shift_r <= rx_byte;
         bit_cnt_r <= bit_cnt_r + 3'h1;
         if (bit_cnt_r == 3'h7)
         begin
            frame_r <= frame_nxt;
            if (byte_cnt_r != CNT_FULL)
               byte_cnt_r <= byte_cnt_r + 3'h1;
            if (frame_r == F_OPC)
               opc_r <= rx_byte;
            if (frame_r == F_ARG)
               addr_r <= {addr_r[15:0], rx_byte};
         end
      end
   end

   // Page buffer: index wraps inside the page, later bytes overwrite earlier
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         buf_vld_r <= '0;
         data_idx_r <= 8'h00;
      end
      else if (pin_s.cs_n)
      begin
         data_idx_r <= 8'h00;
         if (op_r != O_BUSY && !go_busy)
            buf_vld_r <= '0;
      end
      else if (byte_done && frame_r == F_DATA)
      begin
         buf_vld_r[addr_r[7:0] + data_idx_r] <= 1'b1;
         data_idx_r <= data_idx_r + 8'h01;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!pin_s.cs_n && byte_done && frame_r == F_DATA)
         buf_r[addr_r[7:0] + data_idx_r] <= rx_byte;
   end

   // Signature shifter, restarts its byte while clocking continues
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sig_idx_r <= SIG_FIRST_BIT;
         sig_done_r <= 1'b0;
         miso_r <= 1'b0;
      end
      else if (pin_s.cs_n)
      begin
         sig_idx_r <= SIG_FIRST_BIT;
         sig_done_r <= 1'b0;
      end
      else if (frame_r == F_SIG)
      begin
         if (sclk_fall)
         begin
            miso_r <= SIGNATURE[sig_idx_r];
            sig_idx_r <= sig_idx_r - 3'h1;
         end
         if (byte_done)
            sig_done_r <= 1'b1;
      end
   end

   assign spi_miso = miso_r;
   assign spi_miso_oe = frame_r == F_SIG && !pin_s.cs_n;

   assign aligned = bit_cnt_r == 3'h0;
   assign sec_idx = addr_r[MEM_ADDR_W-1 -: SECT_IDX_W];
   assign hit = prot_hit(bp, sec_idx);
   assign go_prog = cs_rise && frame_r == F_DATA && aligned && wel_r && !hit;
   assign go_sect = cs_rise && frame_r == F_ARG && opc_r == SECTOR_CLEAR_CMD &&
                    byte_cnt_r == CNT_SECT && aligned && wel_r && !hit;
   assign go_array = cs_rise && frame_r == F_ARG && opc_r == ARRAY_CLEAR_CMD &&
                     byte_cnt_r == CNT_OPC && aligned && wel_r && bp == 3'h0;
   assign go_busy = op_r == O_STANDBY && (go_prog || go_sect || go_array);
   assign go_sleep = cs_rise && op_r == O_STANDBY && frame_r == F_ARG &&
                     opc_r == SLEEP_ENTRY_CMD && byte_cnt_r == CNT_OPC && aligned;
   assign go_wake = cs_rise && asleep && (frame_r == F_ARG || frame_r == F_SIG) &&
                    opc_r == WAKE_AND_ID_CMD;

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         wel_r <= 1'b0;
      else if (unlock_dec)
         wel_r <= 1'b1;
      else if (go_busy)
         wel_r <= 1'b0;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         op_r <= O_STANDBY;
         tmr_r <= 32'h0;
         kind_r <= K_PROG;
      end
      else
      begin
         if (tmr_r != 32'h0)
            tmr_r <= tmr_r - 32'h1;
         unique case (op_r)
            O_STANDBY:
            begin
               if (go_busy)
               begin
                  op_r <= O_BUSY;
                  kind_r <= go_prog ? K_PROG : (go_sect ? K_SECT : K_ARRAY);
                  tmr_r <= go_prog ? 32'(PAGE_WRITE_CYC) :
                           (go_sect ? 32'(SECTOR_CLEAR_CYC) : 32'(ARRAY_CLEAR_CYC));
               end
               else if (go_sleep)
               begin
                  op_r <= O_SLEEP_WAIT;
                  tmr_r <= 32'(SLEEP_ENTRY_CYC);
               end
            end
            O_BUSY:
               if (tmr_r == 32'h0 && walk_done_r)
                  op_r <= O_STANDBY;
            O_SLEEP_WAIT, O_SLEEP:
            begin
               if (go_wake)
               begin
                  op_r <= O_WAKE_WAIT;
                  tmr_r <= sig_done_r ? 32'(LONG_WAKE_CYC) : 32'(SHORT_WAKE_CYC);
               end
               else if (op_r == O_SLEEP_WAIT && tmr_r == 32'h0)
                  op_r <= O_SLEEP;
            end
            O_WAKE_WAIT:
               if (tmr_r == 32'h0)
                  op_r <= O_STANDBY;
         endcase
      end
   end

   // Address walker for the program, sector and array cycles
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         walk_base_r <= '0;
         walk_cnt_r <= '0;
         walk_end_r <= '0;
         walk_done_r <= 1'b1;
      end
      else if (go_busy)
      begin
         walk_cnt_r <= '0;
         walk_done_r <= 1'b0;
         if (go_prog)
         begin
            walk_base_r <= {addr_r[MEM_ADDR_W-1:PAGE_W], {PAGE_W{1'b0}}};
            walk_end_r <= PAGE_END;
         end
         else if (go_sect)
         begin
            walk_base_r <= {sec_idx, {SECT_W{1'b0}}};
            walk_end_r <= SECT_END;
         end
         else
         begin
            walk_base_r <= '0;
            walk_end_r <= '1;
         end
      end
      else if (op_r == O_BUSY && !walk_done_r)
      begin
         walk_cnt_r <= walk_cnt_r + 1'b1;
         if (walk_cnt_r == walk_end_r)
            walk_done_r <= 1'b1;
      end
   end

   assign mem_we = op_r == O_BUSY && !walk_done_r &&
                   (kind_r != K_PROG || buf_vld_r[walk_cnt_r[PAGE_W-1:0]]);
   assign mem_and_en = kind_r == K_PROG;
   assign mem_wdata = (kind_r == K_PROG) ? buf_r[walk_cnt_r[PAGE_W-1:0]] : ERASED;

   sfpd_array #(.AW(MEM_ADDR_W)) u_array (
      .clk(clk_sys),
      .rst_n(rst_n),
      .we(mem_we),
      .and_en(mem_and_en),
      .addr(walk_base_r | walk_cnt_r),
      .wdata(mem_wdata),
      .peek_addr(peek_addr),
      .peek_data(peek_data)
   );

   assign write_unlock_latch = wel_r;
   assign cycle_in_progress_flag = op_r == O_BUSY;
   assign deep_sleep = op_r == O_SLEEP;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence sleep_req_s;
      go_sleep;
   endsequence
   sequence sleep_wait_s;
      (op_r == O_SLEEP_WAIT && !deep_sleep) [*8];
   endsequence

   wel_set_a: assert property (unlock_dec |=> write_unlock_latch)
      else $error("Write latch not set after unlock opcode");
   busy_start_a: assert property (go_busy |=> cycle_in_progress_flag && !write_unlock_latch)
      else $error("Cycle did not start or latch not cleared");
   wel_clear_a: assert property ($rose(cycle_in_progress_flag) |-> !write_unlock_latch)
      else $error("Write latch still set in cycle");
   page_base_a: assert property (go_prog |=> walk_base_r[PAGE_W-1:0] == 8'h00 && walk_end_r == PAGE_END)
      else $error("Program walk not page aligned");
   prot_block_a: assert property (cs_rise && op_r == O_STANDBY && hit && opc_r != ARRAY_CLEAR_CMD
      |=> !cycle_in_progress_flag)
      else $error("Protected area was written");
   bulk_prot_a: assert property ($rose(cycle_in_progress_flag) && kind_r == K_ARRAY |-> $past(bp) == 3'h0)
      else $error("Array erase with protect bits set");
   sleep_entry_a: assert property (sleep_req_s |=> sleep_wait_s)
      else $error("Deep sleep entered too early");
   sleep_cause_a: assert property ($rose(deep_sleep) |-> $past(op_r) == O_SLEEP_WAIT && $past(tmr_r) == 32'h0)
      else $error("Deep sleep without sleep command");
   busy_reject_a: assert property (byte_done && frame_r == F_OPC && op_r == O_BUSY
      |=> frame_r == F_IGN && cycle_in_progress_flag)
      else $error("Command decoded during busy cycle");
   sleep_filter_a: assert property (byte_done && frame_r == F_OPC && deep_sleep && rx_byte != WAKE_AND_ID_CMD
      |=> frame_r == F_IGN)
      else $error("Command decoded in deep sleep");
   sig_bit_a: assert property (frame_r == F_SIG && sclk_fall |=> spi_miso == SIGNATURE[$past(sig_idx_r)])
      else $error("Wrong signature bit");
endmodule // sfpd_top
`default_nettype wire

// ### design/sfpd_pkg.sv
`default_nettype none
package sfpd_pkg;
   localparam int CLK_PERIOD_NS = 20;
   localparam int PAGE_W = 8;
   localparam int SECT_IDX_W = 3;
   localparam logic [7:0] ERASED = 8'hff;
   localparam logic [2:0] SIG_FIRST_BIT = 3'h7;
   localparam logic [2:0] CNT_OPC = 3'h1;
   localparam logic [2:0] CNT_ADDR_LAST = 3'h3;
   localparam logic [2:0] CNT_SECT = 3'h4;
   localparam logic [2:0] CNT_FULL = 3'h5;
   localparam logic [3:0] SECTORS = 4'h8;
   localparam logic [2:0] BP_ALL = 3'h4;
   localparam int SLEEP_ENTRY_DELAY_US = 3;
   localparam int SHORT_WAKE_DELAY_US = 3;
   localparam int LONG_WAKE_DELAY_US = 30;

   function automatic int sfpd_cyc(input int us);
      int c;
      c = (us * 1000) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int SLEEP_ENTRY_CYC = sfpd_cyc(SLEEP_ENTRY_DELAY_US);
   localparam int SHORT_WAKE_CYC = sfpd_cyc(SHORT_WAKE_DELAY_US);
   localparam int LONG_WAKE_CYC = sfpd_cyc(LONG_WAKE_DELAY_US);

   typedef enum logic [2:0] {
      F_OPC = 3'b000,
      F_ARG = 3'b001,
      F_DATA = 3'b010,
      F_SIG = 3'b011,
      F_IGN = 3'b100
   } sfpd_frame_t;

   typedef enum logic [2:0] {
      O_STANDBY = 3'b000,
      O_BUSY = 3'b001,
      O_SLEEP_WAIT = 3'b010,
      O_SLEEP = 3'b011,
      O_WAKE_WAIT = 3'b100
   } sfpd_op_t;

   typedef enum logic [1:0] {
      K_PROG = 2'b00,
      K_SECT = 2'b01,
      K_ARRAY = 2'b10
   } sfpd_kind_t;

   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic mosi;
   } sfpd_spi_t;
endpackage
`default_nettype wire

// ### design/sfpd_sync.sv
`timescale 1ns/10ps
`default_nettype none
module sfpd_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         logic meta_r;
         logic hold_r;
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               meta_r <= RST_VAL[i];
               hold_r <= RST_VAL[i];
            end
            else
            begin
               meta_r <= d[i];
               hold_r <= meta_r;
            end
         end
         assign q[i] = hold_r;
      end
   endgenerate
endmodule // sfpd_sync
`default_nettype wire

// ### design/sfpd_array.sv
`timescale 1ns/10ps
`default_nettype none
module sfpd_array
   import sfpd_pkg::*;
#(
   parameter int AW = 19
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic we,
   input wire logic and_en,
   input wire logic [AW-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [AW-1:0] peek_addr,
   output logic [7:0] peek_data
);
   logic [7:0] mem [0:(1<<AW)-1];
   logic [7:0] cur;

   // Array starts out erased
   initial
   begin
      for (int i = 0; i < (1 << AW); i++)
         mem[i] = ERASED;
   end

   assign cur = mem[addr];

   always_ff @(posedge clk)
   begin
      if (we)
         mem[addr] <= and_en ? (cur & wdata) : wdata;
      peek_data <= mem[peek_addr];
   end

   no_bit_set_a: assert property (@(posedge clk) disable iff (!rst_n)
      we && and_en |=> (mem[$past(addr)] & ~$past(cur)) == 8'h00)
      else $error("Program turned a zero bit into a one");
endmodule // sfpd_array
`default_nettype wire

// ### bench/sfpd_spi_master.sv
`timescale 1ns/10ps
`default_nettype none
module sfpd_spi_master
   import sfpd_pkg::*;
(
   input wire logic clk,
   input wire logic miso,
   output var sfpd_spi_t spi
);
   initial spi = '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0};

   // Every pin change lands 1 ns after a rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic sel();
      spi.cs_n = 1'b0;
      tick(4);
   endtask

   // Data set while the clock is low; the reply is taken just before the fall
   task automatic bits(input logic [7:0] d, input int n, output logic [7:0] r);
      r = 8'h00;
      for (int i = 0; i < n; i++)
      begin
         spi.mosi = d[7 - i];
         tick(4);
         spi.sclk = 1'b1;
         tick(4);
         r = {r[6:0], miso};
         spi.sclk = 1'b0;
      end
   endtask

   // A released data line shows the inverse of its last bit
   task automatic desel(input int gap);
      tick(4);
      spi.cs_n = 1'b1;
      spi.mosi = ~spi.mosi;
      tick(gap);
   endtask
endmodule // sfpd_spi_master
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import sfpd_pkg::*;
;
   localparam int AW = 12;
   localparam logic [7:0] SIG = 8'h5a; // Arbitrary value
   localparam logic [7:0] UNL = 8'h31;
   localparam logic [7:0] PGM = 8'h32;
   localparam logic [7:0] SEC = 8'h33;
   localparam logic [7:0] ARR = 8'h34;
   localparam logic [7:0] SLP = 8'h35;
   localparam logic [7:0] WAK = 8'h36;
   logic clk_sys = 1'b0;
   logic arst_n;
   logic [2:0] bp;
   logic [AW-1:0] peek_addr;
   logic miso;
   logic miso_oe;
   logic latch;
   logic busy;
   logic sleeping;
   logic [7:0] peek_data;
   logic [7:0] q;
   sfpd_spi_t spi;
   int failures = 0;
   int checks = 0;

   initial forever #10 clk_sys = ~clk_sys;

   // Output line has a pull-up while the device leaves it floating
   sfpd_spi_master partner (.clk(clk_sys), .miso(miso_oe ? miso : 1'b1), .spi(spi));

   sfpd_top #(.MEM_ADDR_W(AW), .PAGE_WRITE_TIME_US(1), .SECTOR_CLEAR_TIME_US(1), .ARRAY_CLEAR_TIME_US(1),
      .SIGNATURE(SIG)) DUT (
      .clk_sys(clk_sys), .arst_n(arst_n), .spi_cs_n(spi.cs_n), .spi_sclk(spi.sclk), .spi_mosi(spi.mosi),
      .spi_miso(miso), .spi_miso_oe(miso_oe), .protect_size_bit2(bp[2]), .protect_size_bit1(bp[1]),
      .protect_size_bit0(bp[0]), .peek_addr(peek_addr), .peek_data(peek_data), .write_unlock_latch(latch),
      .cycle_in_progress_flag(busy), .deep_sleep(sleeping));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chkb(input logic got, input logic exp);
      chk({7'h00, got}, {7'h00, exp});
   endtask

   task automatic rd(input logic [AW-1:0] a, input logic [7:0] e);
      peek_addr = a;
      partner.tick(2);
      chk(peek_data, e);
   endtask

   task automatic frame(input logic [7:0] opc, input logic [23:0] a, input int n);
      partner.sel();
      partner.bits(opc, 8, q);
      for (int i = 0; i < n; i++)
         partner.bits(a[23 - 8 * i -: 8], 8, q);
   endtask

   task automatic cmd(input logic [7:0] opc);
      frame(opc, 24'h000000, 0);
      partner.desel(6);
   endtask

   task automatic prog(input logic [23:0] a, input logic [7:0] d[$], input int tail);
      cmd(UNL);
      frame(PGM, a, 3);
      foreach (d[i])
         partner.bits(d[i], 8, q);
      if (tail > 0)
         partner.bits(8'h00, tail, q);
      partner.desel(6);
   endtask

   task automatic erase_s(input logic [23:0] a, input int n);
      cmd(UNL);
      frame(SEC, a, n);
      partner.desel(6);
   endtask

   task automatic wait_idle(input int lim);
      for (int n = 0; n < lim && busy !== 1'b0; n++)
         partner.tick(1);
   endtask

   task automatic t_reset();
      chkb(latch, 1'b0);
      chkb(busy, 1'b0);
      chkb(sleeping, 1'b0);
      $display("test reset done");
   endtask

   task automatic t_prog();
      logic [7:0] d[$];
      frame(PGM, 24'h0000fe, 3);
      partner.bits(8'h00, 8, q);
      partner.desel(6);
      chkb(busy, 1'b0);
      cmd(UNL);
      chkb(latch, 1'b1);
      d = {8'ha5, 8'h3c, 8'h0f};
      prog(24'hf800fe, d, 0);
      chkb(busy, 1'b1);
      chkb(latch, 1'b0);
      wait_idle(1000);
      chkb(busy, 1'b0);
      rd(12'h0fe, 8'ha5);
      rd(12'h0ff, 8'h3c);
      rd(12'h000, 8'h0f);
      rd(12'h001, 8'hff);
      d = {8'h0f};
      prog(24'h0000fe, d, 0);
      wait_idle(1000);
      rd(12'h0fe, 8'h05);
      d = {8'h00};
      prog(24'h000010, d, 4);
      chkb(busy, 1'b0);
      rd(12'h010, 8'hff);
      d = {};
      for (int k = 0; k < 258; k++)
         d.push_back(k < 256 ? 8'hee : 8'h11);
      prog(24'h000300, d, 0);
      wait_idle(1000);
      rd(12'h300, 8'h11);
      rd(12'h301, 8'h11);
      rd(12'h302, 8'hee);
      $display("test program done");
   endtask

   task automatic t_sect();
      logic [7:0] d[$];
      bp = 3'h1;
      d = {8'h00};
      prog(24'h000e00, d, 0);
      chkb(busy, 1'b0);
      rd(12'he00, 8'hff);
      erase_s(24'h000e00, 3);
      chkb(busy, 1'b0);
      bp = 3'h0;
      erase_s(24'h000123, 2);
      chkb(busy, 1'b0);
      erase_s(24'hf80123, 3);
      chkb(busy, 1'b1);
      wait_idle(2000);
      rd(12'h0fe, 8'hff);
      rd(12'h000, 8'hff);
      rd(12'h302, 8'hee);
      $display("test sector done");
   endtask

   task automatic t_array();
      bp = 3'h4;
      cmd(UNL);
      cmd(ARR);
      chkb(busy, 1'b0);
      bp = 3'h0;
      cmd(UNL);
      frame(ARR, 24'h000000, 0);
      partner.bits(8'h00, 1, q);
      partner.desel(6);
      chkb(busy, 1'b0);
      cmd(UNL);
      cmd(ARR);
      chkb(busy, 1'b1);
      cmd(SLP);
      wait_idle(6000);
      chkb(sleeping, 1'b0);
      rd(12'h302, 8'hff);
      $display("test array done");
   endtask

   task automatic t_sleep();
      cmd(SLP);
      chkb(sleeping, 1'b0);
      partner.tick(160);
      chkb(sleeping, 1'b1);
      cmd(UNL);
      chkb(latch, 1'b0);
      frame(WAK, 24'h000000, 3);
      partner.bits(8'h00, 8, q);
      chk(q, SIG);
      partner.bits(8'h00, 8, q);
      chk(q, SIG);
      partner.desel(6);
      chkb(sleeping, 1'b0);
      partner.tick(200);
      cmd(SLP);
      partner.tick(160);
      chkb(sleeping, 1'b0);
      partner.tick(LONG_WAKE_CYC);
      cmd(SLP);
      partner.tick(160);
      chkb(sleeping, 1'b1);
      frame(WAK, 24'h000000, 0);
      partner.desel(6);
      partner.tick(SHORT_WAKE_CYC);
      cmd(UNL);
      chkb(latch, 1'b1);
      chkb(sleeping, 1'b0);
      $display("test sleep done");
   endtask

   task automatic conclude();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      arst_n = 1'b0;
      bp = 3'h0;
      peek_addr = '0;
      partner.tick(5);
      arst_n = 1'b1;
      partner.tick(4);
      t_reset();
      t_prog();
      t_sect();
      t_array();
      t_sleep();
      conclude();
   end

   initial
   begin
      #2_000_000;
      failures++;
      conclude();
   end
endmodule // tb_top
`default_nettype wire
